/* File: level_ctl.sv */
// Purpose: level control limits, clip guard and offset readback for the left record path
// Assumes: sample inputs come from logic on clk_sys; smp_valid pulses once per sample
// Notes:   smp_level is the output amplitude in 1.5 dB steps below full scale
//
// Notes on behaviour
// - six-bit low target, 0 dBFS down in 1.5 dB steps; below it raise gain
// - no gain raise once the gain ceiling is already reached
// - six-bit high target resets to 0 dBFS; above it reduce gain
// - no gain reduction once the attenuation limit is already reached
// - four-bit gain ceiling, 6 dB per code, resets to all ones
// - four-bit attenuation ceiling, 6 dB per code, resets to all ones
// - hybrid mode caps analogue gain, code 1 is 0 dB, resets to 7
// - hybrid mode floors analogue gain, code 0 reserved, resets to 1
// - clip guard works only while control bit 7 is one; resets off
// - clip guard lowers gain 0.035 dB per sample, doubling per step code
// - clip threshold is (x+1)/128 of full scale
// - clip reduction applies only above the clip threshold
// - offset bits 15 to 8 read back, read only, reset zero
// - offset bits 19 to 16 read back in low nibble, reset zero
// - digital gain only unless hybrid bit set, then analogue plus digital
// - level control runs only while enable bit 3 is set
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "level_ctl_params.svh"
module level_ctl (
  input  wire logic                   clk_sys,       // system clock, 250 MHz
  input  wire logic                   rst,           // async reset, high
  input  wire logic                   ce,            // clock enable, freezes all state
  input  wire logic [7:0]             reg_addr,      // register address
  input  wire logic [7:0]             reg_wdata,     // register write data
  input  wire logic                   reg_wr,        // write strobe
  input  wire logic                   reg_rd,        // read strobe
  output logic      [7:0]             reg_rdata,     // read data, cycle after strobe
  input  wire logic                   smp_valid,     // one pulse per sample
  input  wire logic [5:0]             smp_level,     // output level, 1.5 dB steps below fs
  input  wire logic [15:0]            smp_mag,       // output magnitude, fraction of fs
  input  wire logic [19:0]            offset_corr,   // offset correction value
  output logic      [2:0]             ana_gain_code, // analogue gain code
  output level_ctl_pkg::gain_q_t      dig_gain,      // digital gain, dB times 256
  output level_ctl_pkg::gain_q_t      total_gain,    // total gain, dB times 256
  output logic                        clip_active    // last sample was clip limited
);
  import level_ctl_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] low_output_target;
  logic [7:0] high_output_target;
  logic [7:0] digital_gain_ceilings;
  logic [7:0] analogue_gain_window;
  logic [7:0] clip_guard_control;
  logic [7:0] clip_guard_threshold;
  logic [7:0] offset_corr_middle;
  logic [7:0] offset_corr_top;

  gain_q_t    gain;
  gain_act_t  act;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic gain_q_t db6(input logic [3:0] code);
    db6 = gain_q_t'(code) * `LC_DB6_Q;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic wr_ctrl  = reg_wr && hit(reg_addr, `LC_OFF_CTRL);
  wire logic wr_low   = reg_wr && hit(reg_addr, `LC_OFF_LOW_TGT);
  wire logic wr_high  = reg_wr && hit(reg_addr, `LC_OFF_HIGH_TGT);
  wire logic wr_ceil  = reg_wr && hit(reg_addr, `LC_OFF_DIG_CEIL);
  wire logic wr_ana   = reg_wr && hit(reg_addr, `LC_OFF_ANA_WIN);
  wire logic wr_clipc = reg_wr && hit(reg_addr, `LC_OFF_CLIP_CTRL);
  wire logic wr_clipt = reg_wr && hit(reg_addr, `LC_OFF_CLIP_THR);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl                  <= `LC_RST_CTRL;
      low_output_target     <= `LC_RST_LOW_TGT;
      high_output_target    <= `LC_RST_HIGH_TGT;
      digital_gain_ceilings <= `LC_RST_DIG_CEIL;
      analogue_gain_window  <= `LC_RST_ANA_WIN;
      clip_guard_control    <= `LC_RST_CLIP_CTRL;
      clip_guard_threshold  <= `LC_RST_CLIP_THR;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata & `LC_MASK_CTRL;
      end
      if (wr_low) begin
        low_output_target <= reg_wdata & `LC_MASK_TGT;
      end
      if (wr_high) begin
        high_output_target <= reg_wdata & `LC_MASK_TGT;
      end
      if (wr_ceil) begin
        digital_gain_ceilings <= reg_wdata;
      end
      if (wr_ana) begin
        analogue_gain_window <= reg_wdata & `LC_MASK_ANA_WIN;
      end
      if (wr_clipc) begin
        clip_guard_control <= reg_wdata & `LC_MASK_CLIP_CTRL;
      end
      if (wr_clipt) begin
        clip_guard_threshold <= reg_wdata & `LC_MASK_CLIP_THR;
      end
    end
  end

  // ----------------------------------------------------------------
  // offset correction readback
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      offset_corr_middle <= 8'h00;
      offset_corr_top    <= 8'h00;
    end else if (ce) begin
      offset_corr_middle <= offset_corr[15:8];
      offset_corr_top    <= {4'h0, offset_corr[19:16]};
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_sel;

  always_comb begin
    case (reg_addr)
      `LC_OFF_CTRL:      rd_sel = ctrl;
      `LC_OFF_LOW_TGT:   rd_sel = low_output_target;
      `LC_OFF_HIGH_TGT:  rd_sel = high_output_target;
      `LC_OFF_DIG_CEIL:  rd_sel = digital_gain_ceilings;
      `LC_OFF_ANA_WIN:   rd_sel = analogue_gain_window;
      `LC_OFF_CLIP_CTRL: rd_sel = clip_guard_control;
      `LC_OFF_CLIP_THR:  rd_sel = clip_guard_threshold;
      `LC_OFF_OFS_MID:   rd_sel = offset_corr_middle;
      `LC_OFF_OFS_TOP:   rd_sel = offset_corr_top;
      default:           rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_sel : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire logic       alc_on     = ctrl[`LC_BIT_EN];
  wire logic       hybrid     = ctrl[`LC_BIT_HYBRID];
  wire logic       clip_on    = clip_guard_control[`LC_BIT_CLIP_EN];
  wire logic [1:0] clip_step  = clip_guard_control[1:0];
  wire logic [5:0] low_code   = low_output_target[5:0];
  wire logic [5:0] high_code  = high_output_target[5:0];
  wire gain_q_t    gain_ceil  = db6(digital_gain_ceilings[7:4]);
  wire gain_q_t    atten_ceil = -db6(digital_gain_ceilings[3:0]);

  // ----------------------------------------------------------------
  // sample classification
  // ----------------------------------------------------------------
  // larger level code means a quieter output
  wire logic below_low  = smp_level > low_code;
  wire logic above_high = smp_level < high_code;

  // threshold in magnitude units is (x+1) * 2^16 / 128
  wire logic [7:0]  thr_units = {1'b0, clip_guard_threshold[6:0]} + 8'h01;
  wire logic [16:0] clip_thr  = {thr_units, 9'h000};
  wire logic        above_clip = {1'b0, smp_mag} > clip_thr;

  wire logic at_ceil  = gain >= gain_ceil;
  wire logic at_atten = gain <= atten_ceil;

  always_comb begin
    if (clip_on && above_clip && !at_atten) begin
      act = act_clip;
    end else if (above_high && !at_atten) begin
      act = act_lower;
    end else if (below_low && !above_high && !at_ceil) begin
      act = act_raise;
    end else begin
      act = act_hold;
    end
  end

  // ----------------------------------------------------------------
  // gain update
  // ----------------------------------------------------------------
  wire gain_q_t clip_dec   = `LC_CLIP_BASE_Q <<< clip_step;
  wire gain_q_t up_gain    = gain + `LC_LEVEL_STEP_Q;
  wire gain_q_t down_gain  = gain - `LC_LEVEL_STEP_Q;
  wire gain_q_t clip_gain  = gain - clip_dec;
  gain_q_t      next_gain;

  always_comb begin
    case (act)
      act_raise: next_gain = (up_gain > gain_ceil) ? gain_ceil : up_gain;
      act_lower: next_gain = (down_gain < atten_ceil) ? atten_ceil : down_gain;
      act_clip:  next_gain = (clip_gain < atten_ceil) ? atten_ceil : clip_gain;
      act_hold:  next_gain = gain;
      default:   next_gain = gain;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gain        <= '0;
      clip_active <= 1'b0;
    end else if (ce) begin
      if (!alc_on) begin
        gain        <= '0;
        clip_active <= 1'b0;
      end else if (smp_valid) begin
        gain        <= next_gain;
        clip_active <= (act == act_clip);
      end
    end
  end

  assign total_gain = gain;

  // ----------------------------------------------------------------
  // analogue and digital split
  // ----------------------------------------------------------------
  level_cfg_if cfg ();

  assign cfg.hybrid     = hybrid;
  assign cfg.ana_max    = analogue_gain_window[6:4];
  assign cfg.ana_min    = analogue_gain_window[2:0];
  assign cfg.gain_total = gain;

  level_gain_split u_split (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .cfg     (cfg.split)
  );

  assign ana_gain_code = cfg.ana_code;
  assign dig_gain      = cfg.dig_gain;
endmodule
`default_nettype wire

/* File: level_ctl_params.svh */
// Purpose: offsets, field positions, reset values and gain scaling of the level control
// Assumes: 8-bit register addresses and data
// Notes:   gain values are dB in fixed point with eight fraction bits
`ifndef LEVEL_CTL_PARAMS_SVH
`define LEVEL_CTL_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LC_OFF_CTRL        8'h2f
`define LC_OFF_LOW_TGT     8'h9d
`define LC_OFF_HIGH_TGT    8'h9e
`define LC_OFF_DIG_CEIL    8'h9f
`define LC_OFF_ANA_WIN     8'ha0
`define LC_OFF_CLIP_CTRL   8'ha1
`define LC_OFF_CLIP_THR    8'ha2
`define LC_OFF_OFS_MID     8'ha3
`define LC_OFF_OFS_TOP     8'ha4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LC_RST_CTRL        8'h00
`define LC_RST_LOW_TGT     8'h3f
`define LC_RST_HIGH_TGT    8'h00
`define LC_RST_DIG_CEIL    8'hff
`define LC_RST_ANA_WIN     8'h71
`define LC_RST_CLIP_CTRL   8'h00
`define LC_RST_CLIP_THR    8'h00

// ----------------------------------------------------------------
// writable bit masks and field positions
// ----------------------------------------------------------------
`define LC_MASK_CTRL       8'h0a
`define LC_MASK_TGT        8'h3f
`define LC_MASK_ANA_WIN    8'h77
`define LC_MASK_CLIP_CTRL  8'h83
`define LC_MASK_CLIP_THR   8'h7f
`define LC_BIT_EN          3
`define LC_BIT_HYBRID      1
`define LC_BIT_CLIP_EN     7

// ----------------------------------------------------------------
// gain scaling, dB times 256
// ----------------------------------------------------------------
`define LC_DB6_Q           18'sd1536
`define LC_LEVEL_STEP_Q    18'sd384
`define LC_CLIP_BASE_Q     18'sd9
`define LC_THR_SHIFT       9
`define LC_ANA_CODE_0DB    3'h1

`endif

/* File: level_ctl_pkg.sv */
// Purpose: types shared by the level control files
// Assumes: params header gives the scaling
// Notes:   none
package level_ctl_pkg;
  typedef logic signed [17:0] gain_q_t;
  typedef enum logic [1:0] {
    act_hold,
    act_raise,
    act_lower,
    act_clip
  } gain_act_t;
endpackage

/* File: level_cfg_if.sv */
// Purpose: carries total gain and analogue window to the gain splitter
// Assumes: one clock domain
// Notes:   split results travel back on the same interface
`timescale 1ns/100ps
`default_nettype none
interface level_cfg_if;
  import level_ctl_pkg::*;
  logic          hybrid;
  logic [2:0]    ana_max;
  logic [2:0]    ana_min;
  gain_q_t       gain_total;
  logic [2:0]    ana_code;
  gain_q_t       dig_gain;
  modport src   (output hybrid, ana_max, ana_min, gain_total, input ana_code, dig_gain);
  modport split (input hybrid, ana_max, ana_min, gain_total, output ana_code, dig_gain);
endinterface
`default_nettype wire

/* File: level_gain_split.sv */
// Purpose: splits the total gain into analogue and digital parts
// Assumes: analogue steps of 6 dB, code 1 is 0 dB
// Notes:   reserved code 0 in the window is treated as code 1
`timescale 1ns/100ps
`default_nettype none
`include "level_ctl_params.svh"
module level_gain_split (
  input  wire logic clk_sys,   // system clock
  input  wire logic rst,       // async reset, high
  input  wire logic ce,        // clock enable
  level_cfg_if.split cfg       // gain and window in, split out
);
  import level_ctl_pkg::*;

  // ----------------------------------------------------------------
  // analogue code selection
  // ----------------------------------------------------------------
  function automatic logic [2:0] fix_code(input logic [2:0] c);
    fix_code = (c == 3'h0) ? `LC_ANA_CODE_0DB : c;
  endfunction

  function automatic logic [2:0] steps_of(input gain_q_t g);
    logic [2:0] s;
    s = 3'h0;
    for (int k = 1; k < 7; k++) begin
      if (g >= 18'(k * 1536)) begin
        s = 3'(k);
      end
    end
    steps_of = s;
  endfunction

  wire logic [2:0] lo_code  = fix_code(cfg.ana_min);
  wire logic [2:0] hi_code  = fix_code(cfg.ana_max);
  wire logic [2:0] raw_code = steps_of(cfg.gain_total) + 3'h1;
  wire logic [2:0] up_code  = (raw_code < lo_code) ? lo_code : raw_code;
  wire logic [2:0] win_code = (up_code > hi_code) ? hi_code : up_code;
  wire logic [2:0] sel_code = cfg.hybrid ? win_code : `LC_ANA_CODE_0DB;
  wire gain_q_t    ana_q    = gain_q_t'(sel_code - 3'h1) * `LC_DB6_Q;
  wire gain_q_t    dig_q    = cfg.gain_total - ana_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg.ana_code <= `LC_ANA_CODE_0DB;
      cfg.dig_gain <= '0;
    end else if (ce) begin
      cfg.ana_code <= sel_code;
      cfg.dig_gain <= dig_q;
    end
  end
endmodule
`default_nettype wire

/* File: adc_left_src.sv */
// Purpose: stand-in for the left adc sample path feeding the level control
// Assumes: bench sets level, magnitude and the longest gap between samples
// Notes:   between samples the level and magnitude lines invert on every cycle
`timescale 1ns/100ps
`default_nettype none
module adc_left_src (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        rst,        // async reset, high
  input  wire logic [5:0]  lvl,        // level of the next sample
  input  wire logic [15:0] mag,        // magnitude of the next sample
  input  wire logic [3:0]  gap,        // longest idle run between samples
  output logic             smp_valid,  // sample pulse
  output logic      [5:0]  smp_level,  // sample level
  output logic      [15:0] smp_mag,    // sample magnitude
  output logic      [19:0] offset_corr // offset correction value
);
  int seed = 32'h7d35b535;
  int wait_n;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smp_valid <= 1'b0;
      smp_level <= 6'h00;
      smp_mag <= 16'h0000;
      offset_corr <= 20'h00000;
      wait_n <= 0;
    end else begin
      smp_valid <= (wait_n == 0);
      smp_level <= (wait_n == 0) ? lvl : ~smp_level;
      smp_mag <= (wait_n == 0) ? mag : ~smp_mag;
      wait_n <= (wait_n == 0) ? {$random(seed)} % (gap + 1) : wait_n - 1;
      if ({$random(seed)} % 16 == 0)
        offset_corr <= 20'($random(seed));
    end
  end
endmodule
`default_nettype wire

/* File: level_ctl_chk.sv */
// Purpose: port-level assertions on level_ctl
// Assumes: one clock, async high reset
// Notes:   bound into every level_ctl
`timescale 1ns/100ps
`default_nettype none
`include "level_ctl_params.svh"
module level_ctl_chk
  import level_ctl_pkg::*;
(
  input wire logic        clk_sys,       // system clock
  input wire logic        rst,           // async reset, high
  input wire logic        ce,            // clock enable
  input wire logic        reg_wr,        // write strobe
  input wire logic        reg_rd,        // read strobe
  input wire logic [7:0]  reg_addr,      // register address
  input wire logic [7:0]  reg_wdata,     // write data
  input wire logic [7:0]  reg_rdata,     // read data
  input wire logic        smp_valid,     // sample pulse
  input wire logic        clip_active,   // clip flag
  input wire logic [5:0]  smp_level,     // sample level
  input wire logic [15:0] smp_mag,       // sample magnitude
  input wire logic [19:0] offset_corr,   // offset value
  input wire logic [2:0]  ana_gain_code, // analogue code
  input wire gain_q_t     dig_gain,      // digital gain
  input wire gain_q_t     total_gain     // total gain
);
  wire logic [7:0] ofs_mid = offset_corr[15:8];
  wire logic [3:0] ofs_top = offset_corr[19:16];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence rd_at(logic [7:0] a);
    ce && reg_rd && reg_addr == a && $past(ce) && $stable(offset_corr);
  endsequence
  sequence smp_take;
    ce && smp_valid;
  endsequence
  chk_rd_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_mid_copy: assert property (rd_at(`LC_OFF_OFS_MID) |=> reg_rdata == $past(ofs_mid))
    else $error("offset middle readback wrong");
  chk_top_copy: assert property (rd_at(`LC_OFF_OFS_TOP) |=> reg_rdata == {4'h0, $past(ofs_top)})
    else $error("offset top readback wrong");
  chk_gain_span: assert property (total_gain <= 18'sh05a00 && total_gain >= -18'sh05a00)
    else $error("gain outside 90 dB span");
  chk_hold_gain: assert property (!smp_valid |=> total_gain == $past(total_gain) || total_gain == 0)
    else $error("gain moved without sample");
  chk_step_bound: assert property (smp_take |=> total_gain == 0 ||
    (total_gain - $past(total_gain) <= 18'sh00180 &&
    $past(total_gain) - total_gain <= 18'sh00180))
    else $error("gain step too large");
  chk_split_sum: assert property ($past(ce) |-> dig_gain ==
    gain_q_t'($past(total_gain) - ({15'h0, ana_gain_code} - 18'h1) * 18'h600))
    else $error("gain split does not add up");
  chk_code_legal: assert property (ana_gain_code != 3'h0)
    else $error("reserved analogue code");
  chk_clip_cause: assert property ($rose(clip_active) |-> $past(smp_valid) && $past(ce) &&
    $past(smp_mag) > 16'h0200 && total_gain < $past(total_gain))
    else $error("clip flag without cause");
endmodule
bind level_ctl level_ctl_chk u_chk (.clk_sys, .reg_wr, .reg_rd, .ce, .rst, .reg_addr,
  .reg_wdata, .reg_rdata, .smp_valid, .clip_active, .smp_level, .smp_mag, .offset_corr,
  .ana_gain_code, .dig_gain, .total_gain);
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench of level_ctl against a behavioural model
// Assumes: adc_left_src supplies samples and offset
// Notes:   model is compared at every clock-enabled edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import level_ctl_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, erd, a, d;
  logic [5:0] lvl = 6'h3f, smp_level;
  logic [15:0] mag = 16'h0000, smp_mag;
  logic [3:0] gap = 4'h0;
  logic [19:0] offset_corr;
  logic smp_valid, clip_active, chk_rd, chk_cl;
  logic [2:0] ana_gain_code;
  gain_q_t dig_gain, total_gain;
  logic [7:0] rg [0:255];
  logic [7:0] adr [10] = '{8'h2f, 8'h9d, 8'h9e, 8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hff};
  int seed = 32'h7d35b535;
  int num_errors = 0, n_compared = 0, cycles = 0, g, ea, ed, ofs, cl;
  always #2 clk_sys = ~clk_sys;
  level_ctl u_level_ctl (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .smp_valid, .smp_level, .smp_mag, .offset_corr, .ana_gain_code, .dig_gain,
    .total_gain, .clip_active);
  adc_left_src u_adc_left_src (.clk_sys, .rst, .lvl, .mag, .gap, .smp_valid, .smp_level,
    .smp_mag, .offset_corr);
  // ----------------------------------------------------------------
  // model
  // ----------------------------------------------------------------
  function automatic logic [7:0] msk(input logic [7:0] x);
    case (x)
      8'h2f: return 8'h0a;
      8'h9d, 8'h9e: return 8'h3f;
      8'h9f: return 8'hff;
      8'ha0: return 8'h77;
      8'ha1: return 8'h83;
      8'ha2: return 8'h7f;
      default: return 8'h00;
    endcase
  endfunction
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic split();
    int k;
    ea = 1;
    ed = g;
    if (rg[8'h2f][1]) begin
      k = (g < 0) ? 1 : 1 + g / 1536;
      if (k > 7) k = 7;
      if (k > int'(rg[8'ha0][6:4])) k = rg[8'ha0][6:4];
      if (k < int'(rg[8'ha0][2:0])) k = rg[8'ha0][2:0];
      if (k < 1) k = 1;
      ea = k;
      ed = g - (k - 1) * 1536;
    end
  endtask
  task automatic step();
    int at, cg;
    at = int'(rg[8'h9f][3:0]) * 1536;
    cg = int'(rg[8'h9f][7:4]) * 1536;
    chk_cl = 1'b0;
    if (!rg[8'h2f][3]) g = 0;
    else if (smp_valid) begin
      chk_cl = 1'b1;
      cl = 0;
      if (rg[8'ha1][7] && smp_mag > (int'(rg[8'ha2][6:0]) + 1) * 512 && g > -at) begin
        g = g - (9 << rg[8'ha1][1:0]);
        if (g < -at) g = -at;
        cl = 1;
      end else if (smp_level < rg[8'h9e][5:0]) begin
        if (g > -at) g = (g - 384 < -at) ? -at : g - 384;
      end else if (smp_level > rg[8'h9d][5:0] && g < cg)
        g = (g + 384 > cg) ? cg : g + 384;
    end
  endtask
  always @(posedge clk_sys) begin
    if (rst) begin
      foreach (rg[i]) rg[i] = 8'h00;
      rg[8'h9d] = 8'h3f;
      rg[8'h9f] = 8'hff;
      rg[8'ha0] = 8'h71;
      {g, ed, ofs, cl, chk_rd, chk_cl} = '0;
      ea = 1;
    end else if (ce) begin
      cmp(total_gain, 18'(g), "total gain");
      cmp(dig_gain, 18'(ed), "digital gain");
      cmp(ana_gain_code, 18'(ea), "analogue code");
      if (chk_rd) cmp(reg_rdata, erd, "read data");
      if (chk_cl) cmp(clip_active, 18'(cl), "clip flag");
      split();
      step();
      chk_rd = reg_rd;
      erd = (reg_addr == 8'ha3) ? ofs[15:8] : (reg_addr == 8'ha4) ? {4'h0, ofs[19:16]} : rg[reg_addr];
      if (reg_wr) rg[reg_addr] = reg_wdata & msk(reg_addr);
      ofs = offset_corr;
    end
  end
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] dt);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (adr[i]) bus(1'b0, 1'b1, adr[i], 8'h00);
    $display("test reset values done");
    bus(1'b1, 1'b0, 8'h9f, 8'h21);
    bus(1'b1, 1'b0, 8'h9e, 8'h04);
    bus(1'b1, 1'b0, 8'h9d, 8'h3e);
    bus(1'b1, 1'b0, 8'h2f, 8'h08);
    bus(1'b1, 1'b0, 8'ha2, 8'h10);
    for (int s = 0; s < 4; s++) begin
      lvl <= 6'h3f;
      mag <= 16'h0000;
      idle(60);
      cmp(total_gain, 18'd3072, "gain ceiling");
      bus(1'b1, 1'b0, 8'ha1, 8'h80 | 8'(s));
      lvl <= 6'h20;
      mag <= 16'h2200;
      idle(30);
      cmp(total_gain, 18'd3072, "clip at threshold");
      mag <= 16'h2201;
      idle(600);
      cmp(total_gain, -18'sd1536, "clip floor");
    end
    $display("test clip guard done");
    bus(1'b1, 1'b0, 8'ha1, 8'h00);
    lvl <= 6'h00;
    idle(40);
    cmp(total_gain, -18'sd1536, "attenuation limit");
    bus(1'b1, 1'b0, 8'h9f, 8'hff);
    bus(1'b1, 1'b0, 8'ha0, 8'h52);
    bus(1'b1, 1'b0, 8'h2f, 8'h0a);
    lvl <= 6'h3f;
    idle(200);
    cmp(ana_gain_code, 18'd5, "analogue ceiling");
    lvl <= 6'h00;
    idle(200);
    cmp(ana_gain_code, 18'd2, "analogue floor");
    bus(1'b1, 1'b0, 8'h2f, 8'h02);
    idle(3);
    cmp(total_gain, 18'd0, "disabled gain");
    $display("test gain limits done");
    gap <= 4'h3;
    repeat (300) begin
      ce <= ($random(seed) % 4 != 0);
      lvl <= 6'($random(seed));
      mag <= 16'($random(seed));
      a = adr[{$random(seed)} % 10];
      d = 8'($random(seed));
      if (a == 8'ha0) d[6:4] = 3'h7;
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b1, a, 8'h00);
    end
    ce <= 1'b1;
    idle(4);
    $display("test random access done");
    conclude();
  end
endmodule
`default_nettype wire
